// ---- tbd_consts.vh ----
// constants for the type b branch, load and store decode stage
`ifndef TBD_CONSTS_VH
`define TBD_CONSTS_VH

// field positions, bit 31 of the encoding is the msb
`define TBD_OPC_HI     31
`define TBD_OPC_LO     26
`define TBD_RD_HI      25
`define TBD_RD_LO      21
`define TBD_RA_HI      20
`define TBD_RA_LO      16
`define TBD_FN_HI      10
`define TBD_FN_LO      0
`define TBD_IMM_HI     15
`define TBD_IMM_LO     0

// primary opcodes
`define TBD_OP_AND_LITERAL    6'h29
`define TBD_OP_XOR_LITERAL    6'h2A
`define TBD_OP_AND_NOT_LITERAL   6'h2B
`define TBD_OP_IMM     6'h2C
`define TBD_OP_RET     6'h2D
`define TBD_OP_BRI     6'h2E
`define TBD_OP_BCI     6'h2F
`define TBD_OP_LBU     6'h30
`define TBD_OP_LHU     6'h31
`define TBD_OP_LW      6'h32
`define TBD_OP_SB      6'h34
`define TBD_OP_SH      6'h35
`define TBD_OP_SW      6'h36
`define TBD_OP_LBUI    6'h38
`define TBD_OP_LHUI    6'h39
`define TBD_OP_LWI     6'h3A
`define TBD_OP_LLI     6'h3B
`define TBD_OP_SBI     6'h3C
`define TBD_OP_SHI     6'h3D
`define TBD_OP_SWI     6'h3E
`define TBD_OP_SLI     6'h3F

// return sub-codes in the destination field
`define TBD_RT_SUB     5'h10
`define TBD_RT_INT     5'h11
`define TBD_RT_BRK     5'h12
`define TBD_RT_EXC     5'h14

// immediate branch sub-codes in the first source field
`define TBD_BR_REL     5'h00
`define TBD_BR_RELD    5'h10
`define TBD_BR_RELL    5'h14
`define TBD_BR_ABS     5'h08
`define TBD_BR_ABSD    5'h18
`define TBD_BR_ABSL    5'h1C
`define TBD_BR_BRK     5'h0C
`define TBD_BR_BAR     5'h02

// function field patterns
`define TBD_FN_PLAIN   11'h000
`define TBD_FN_EA      11'h080
`define TBD_FN_LONG    11'h100
`define TBD_FN_RES     11'h400

// access sizes
`define TBD_SZ_BYTE    2'h0
`define TBD_SZ_HALF    2'h1
`define TBD_SZ_WORD    2'h2
`define TBD_SZ_LONG    2'h3

`define TBD_PC_STEP    64'h4
`define TBD_RST_BIT    1'h0
`define TBD_RST_WORD   64'h0

`endif

// ---- tbd_core.v ----
// decode and execute stage for literal logic, branch, return, load and store
`timescale 1ns/10ps
`include "tbd_consts.vh"
// Operation
// - interrupt return jumps to source plus literal, sets interrupt enable.
// - break return jumps to source plus literal, clears break-in-progress.
// - exception return jumps, sets exception enable, clears in-progress and status.
// - barrier advances pc by four after outstanding accesses complete.
// - relative branch with link adds literal, saves own address.
// - absolute branches load literal into pc; link form saves pc.
// - break literal jumps, saves pc, sets break-in-progress.
// - conditional branches add literal when condition holds; top bit selects delay.
// - low condition bits compare source signed against zero.
// - byte loads zero-fill upper bits, byte in low bits.
// - halfword loads zero-fill upper bits, halfword in low bits.
// - indexed word loads address with sum of both sources.
// - literal word loads address with source plus sign-extended literal.
// - extended-address forms concatenate both sources instead of adding.
// - reserving word load loads and sets the reservation.
// - conditional store writes only if reserved; always clears reservation.
// - byte stores write low destination byte.
// - halfword stores write low destination halfword.
// - word stores write whole destination word.
// - long accesses use 64-bit address and 64-bit data.
// - wide prefix and long accesses valid only in 64-bit configuration.
// - conditional store clears carry on success, sets carry on failure.
// - reset, interrupt, exception and break clear the reservation; a reserving load's set wins over a same-cycle clear.
// - encoding bit 31 is the most significant bit.
module tbd_core (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        mode64_i,
   input  wire        inst_valid_i,
   input  wire [31:0] instr_i,
   input  wire [63:0] pc_i,
   input  wire [63:0] ra_val_i,
   input  wire [63:0] rb_val_i,
   input  wire [63:0] rd_val_i,
   input  wire        rsv_clear_i,
   input  wire        mem_ack_i,
   input  wire [63:0] mem_rdata_i,
   input  wire        mem_idle_i,
   output wire        ready_o,
   output wire        illegal_o,
   output wire        wb_en_o,
   output wire [4:0]  wb_addr_o,
   output wire [63:0] wb_data_o,
   output wire        br_o,
   output wire        br_delay_o,
   output wire [63:0] br_target_o,
   output wire        mem_req_o,
   output wire        mem_we_o,
   output wire [1:0]  mem_size_o,
   output wire [63:0] mem_addr_o,
   output wire [63:0] mem_wdata_o,
   output wire        msr_ie_o,
   output wire        msr_bip_o,
   output wire        msr_ee_o,
   output wire        msr_eip_o,
   output wire        msr_c_o,
   output wire        esr_clear_o,
   output wire        rsv_o
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_MEM  = 3'b010;
   localparam [2:0] ST_BAR  = 3'b100;

   reg [2:0]  state_ff;
   reg        m64_meta_ff, m64_ff, ready_ff, ill_ff, wb_en_ff, br_ff, br_delay_ff, mreq_ff;
   reg        mwe_ff, ie_ff, bip_ff, ee_ff, eip_ff, c_ff, esr_clr_ff, rsv_ff, ld_rsv_ff;
   reg        hi_vld_ff, wide_vld_ff;
   reg [4:0]  wb_addr_ff;
   reg [63:0] wb_data_ff, br_tgt_ff, maddr_ff, mwdata_ff;
   reg [1:0]  msize_ff;
   reg [15:0] hi_ff;
   reg [23:0] wide_ff;

   reg [2:0]  nxt_state;
   reg        nxt_ready, nxt_ill, nxt_wb_en, nxt_br, nxt_br_delay, nxt_mreq, nxt_mwe, nxt_ie;
   reg        nxt_bip, nxt_ee, nxt_eip, nxt_c, nxt_esr_clr, nxt_rsv, nxt_ld_rsv, nxt_hi_vld;
   reg        nxt_wide_vld;
   reg [4:0]  nxt_wb_addr;
   reg [63:0] nxt_wb_data, nxt_br_tgt, nxt_maddr, nxt_mwdata;
   reg [1:0]  nxt_msize;
   reg [15:0] nxt_hi;
   reg [23:0] nxt_wide;

   wire [5:0]  opc    = instr_i[`TBD_OPC_HI:`TBD_OPC_LO];
   wire [4:0]  rd_fld = instr_i[`TBD_RD_HI:`TBD_RD_LO];
   wire [4:0]  ra_fld = instr_i[`TBD_RA_HI:`TBD_RA_LO];
   wire [10:0] fn_fld = instr_i[`TBD_FN_HI:`TBD_FN_LO];
   wire [15:0] lit    = instr_i[`TBD_IMM_HI:`TBD_IMM_LO];
   wire        take   = inst_valid_i & ready_ff;

   wire [63:0] imm_x = wide_vld_ff ? {{24{wide_ff[23]}}, wide_ff, lit} :
                       hi_vld_ff   ? {{32{hi_ff[15]}}, hi_ff, lit} :
                                     {{48{lit[15]}}, lit};

   // 32-bit configuration sees only the low word, sign extended
   wire [63:0] ra_s = m64_ff ? ra_val_i : {{32{ra_val_i[31]}}, ra_val_i[31:0]};
   wire        ra_z = (ra_s == `TBD_RST_WORD);
   wire        ra_n = ra_s[63];
   wire [63:0] ra_lit = ra_val_i + imm_x;
   wire [63:0] pc_lit = pc_i + imm_x;

   reg cond_ok;
   reg cond_vld;
   always @* begin
      cond_vld = 1'b1;
      case (rd_fld[2:0])
         3'h0:    cond_ok = ra_z;
         3'h1:    cond_ok = ~ra_z;
         3'h2:    cond_ok = ra_n;
         3'h3:    cond_ok = ra_n | ra_z;
         3'h4:    cond_ok = ~ra_n & ~ra_z;
         3'h5:    cond_ok = ~ra_n;
         default: begin
            cond_ok  = 1'b0;
            cond_vld = 1'b0;
         end
      endcase
   end

   // load and store decode: op bit 2 store, bit 3 literal form, bits 1:0 size
   wire        ls_op  = (opc[5:4] == 2'b11) & (opc[1:0] != 2'b11 | opc[3]);
   wire        ls_st  = opc[2];
   wire        ls_lit = opc[3];
   wire        fn_ea  = (fn_fld == `TBD_FN_EA);
   wire        fn_res = (fn_fld == `TBD_FN_RES) & (opc[1:0] == `TBD_SZ_WORD);
   wire        fn_lng = (fn_fld == `TBD_FN_LONG) & (opc[1:0] == `TBD_SZ_WORD);
   wire        fn_ok  = (fn_fld == `TBD_FN_PLAIN) | fn_ea | fn_res | (fn_lng & m64_ff);
   wire [1:0]  ls_sz  = fn_lng ? `TBD_SZ_LONG : opc[1:0];
   // long literal forms need 64-bit mode
   wire        ls_ok  = ls_op & (ls_lit ? (opc[1:0] != 2'b11 | m64_ff) : fn_ok);

   wire [63:0] ea_cat = {ra_val_i[31:0], rb_val_i[31:0]};
   wire [63:0] ea_sum = ra_val_i + rb_val_i;
   wire [63:0] ls_adr = ls_lit ? ra_lit : (fn_ea ? ea_cat : ea_sum);

   reg [63:0] st_data;
   always @* begin
      case (ls_sz)
         `TBD_SZ_BYTE: st_data = {56'h0, rd_val_i[7:0]};
         `TBD_SZ_HALF: st_data = {48'h0, rd_val_i[15:0]};
         `TBD_SZ_WORD: st_data = {32'h0, rd_val_i[31:0]};
         default:      st_data = rd_val_i;
      endcase
   end

   reg [63:0] ld_data;
   always @* begin
      case (msize_ff)
         `TBD_SZ_BYTE: ld_data = {56'h0, mem_rdata_i[7:0]};
         `TBD_SZ_HALF: ld_data = {48'h0, mem_rdata_i[15:0]};
         `TBD_SZ_WORD: ld_data = {32'h0, mem_rdata_i[31:0]};
         default:      ld_data = mem_rdata_i;
      endcase
   end

   always @* begin
      nxt_state    = state_ff;
      nxt_ill      = 1'b0;
      nxt_wb_en    = 1'b0;
      nxt_wb_addr  = wb_addr_ff;
      nxt_wb_data  = wb_data_ff;
      nxt_br       = 1'b0;
      nxt_br_delay = 1'b0;
      nxt_br_tgt   = br_tgt_ff;
      nxt_mreq     = mreq_ff;
      nxt_mwe      = mwe_ff;
      nxt_msize    = msize_ff;
      nxt_maddr    = maddr_ff;
      nxt_mwdata   = mwdata_ff;
      nxt_ie       = ie_ff;
      nxt_bip      = bip_ff;
      nxt_ee       = ee_ff;
      nxt_eip      = eip_ff;
      nxt_c        = c_ff;
      nxt_esr_clr  = 1'b0;
      nxt_ld_rsv   = ld_rsv_ff;
      nxt_hi_vld   = hi_vld_ff;
      nxt_hi       = hi_ff;
      nxt_wide_vld = wide_vld_ff;
      nxt_wide     = wide_ff;
      // external break, interrupt or exception drops reservation
      nxt_rsv      = rsv_ff & ~rsv_clear_i;
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               // prefixes cover only the very next instruction
               nxt_hi_vld   = 1'b0;
               nxt_wide_vld = 1'b0;
               nxt_wb_addr  = rd_fld;
               case (opc)
                  `TBD_OP_AND_LITERAL: begin
                     nxt_wb_en   = 1'b1;
                     nxt_wb_data = ra_val_i & imm_x;
                  end
                  `TBD_OP_XOR_LITERAL: begin
                     nxt_wb_en   = 1'b1;
                     nxt_wb_data = ra_val_i ^ imm_x;
                  end
                  `TBD_OP_AND_NOT_LITERAL: begin
                     nxt_wb_en   = 1'b1;
                     nxt_wb_data = ra_val_i & ~imm_x;
                  end
                  `TBD_OP_IMM: begin
                     if (rd_fld == 5'h00 && ra_fld == 5'h00) begin
                        nxt_hi_vld = 1'b1;
                        nxt_hi     = lit;
                     // wide prefix only in 64-bit mode
                     end else if (rd_fld[4:3] == 2'b10 && m64_ff) begin
                        nxt_wide_vld = 1'b1;
                        nxt_wide     = instr_i[23:0];
                     end else begin
                        nxt_ill = 1'b1;
                     end
                  end
                  `TBD_OP_RET: begin
                     nxt_br       = 1'b1;
                     nxt_br_delay = 1'b1;
                     nxt_br_tgt   = ra_lit;
                     case (rd_fld)
                        `TBD_RT_SUB: nxt_ie = ie_ff;
                        `TBD_RT_INT: nxt_ie = 1'b1;
                        `TBD_RT_BRK: nxt_bip = 1'b0;
                        `TBD_RT_EXC: begin
                           nxt_ee      = 1'b1;
                           nxt_eip     = 1'b0;
                           nxt_esr_clr = 1'b1;
                        end
                        default: begin
                           nxt_br  = 1'b0;
                           nxt_ill = 1'b1;
                        end
                     endcase
                  end
                  `TBD_OP_BRI: begin
                     nxt_br       = 1'b1;
                     nxt_br_delay = ra_fld[4];
                     nxt_wb_en    = ra_fld[2];
                     nxt_wb_data  = pc_i;
                     nxt_br_tgt   = ra_fld[3] ? imm_x : pc_lit;
                     case (ra_fld)
                        `TBD_BR_REL, `TBD_BR_RELD, `TBD_BR_RELL,
                        `TBD_BR_ABS, `TBD_BR_ABSD, `TBD_BR_ABSL: nxt_ill = 1'b0;
                        `TBD_BR_BRK: begin
                           nxt_bip = 1'b1;
                           nxt_rsv = 1'b0;
                        end
                        `TBD_BR_BAR: begin
                           nxt_br     = 1'b0;
                           nxt_wb_en  = 1'b0;
                           nxt_br_tgt = pc_i + `TBD_PC_STEP;
                           nxt_state  = ST_BAR;
                        end
                        default: begin
                           nxt_br    = 1'b0;
                           nxt_wb_en = 1'b0;
                           nxt_ill   = 1'b1;
                        end
                     endcase
                  end
                  `TBD_OP_BCI: begin
                     nxt_br       = cond_vld & cond_ok;
                     nxt_br_delay = cond_vld & cond_ok & rd_fld[4];
                     nxt_br_tgt   = pc_lit;
                     nxt_ill      = ~cond_vld | rd_fld[3];
                  end
                  default: begin
                     if (ls_ok) begin
                        nxt_msize  = ls_sz;
                        nxt_maddr  = ls_adr;
                        nxt_mwdata = st_data;
                        nxt_mwe    = ls_st;
                        nxt_ld_rsv = ~ls_st & fn_res & ~ls_lit;
                        nxt_mreq   = 1'b1;
                        nxt_state  = ST_MEM;
                        if (ls_st & fn_res & ~ls_lit) begin
                           nxt_rsv = 1'b0;
                           nxt_c   = ~rsv_ff;
                           if (!rsv_ff) begin
                              nxt_mreq  = 1'b0;
                              nxt_state = ST_IDLE;
                           end
                        end
                     end else begin
                        nxt_ill = 1'b1;
                     end
                  end
               endcase
            end
         end
         ST_MEM: begin
            if (mem_ack_i) begin
               nxt_mreq    = 1'b0;
               nxt_state   = ST_IDLE;
               nxt_wb_en   = ~mwe_ff;
               nxt_wb_data = ld_data;
               // reservation set wins over a same-cycle clear
               if (ld_rsv_ff) begin
                  nxt_rsv = 1'b1;
               end
            end
         end
         ST_BAR: begin
            if (mem_idle_i) begin
               nxt_br    = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      nxt_ready = (nxt_state == ST_IDLE);
   end

   // mode strap arrives from a pin
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         m64_meta_ff <= `TBD_RST_BIT;
         m64_ff      <= `TBD_RST_BIT;
      end else begin
         m64_meta_ff <= mode64_i;
         m64_ff      <= m64_meta_ff;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff    <= ST_IDLE;
         ready_ff    <= `TBD_RST_BIT;
         ill_ff      <= `TBD_RST_BIT;
         wb_en_ff    <= `TBD_RST_BIT;
         wb_addr_ff  <= 5'h00;
         wb_data_ff  <= `TBD_RST_WORD;
         br_ff       <= `TBD_RST_BIT;
         br_delay_ff <= `TBD_RST_BIT;
         br_tgt_ff   <= `TBD_RST_WORD;
         mreq_ff     <= `TBD_RST_BIT;
         mwe_ff      <= `TBD_RST_BIT;
         msize_ff    <= `TBD_SZ_BYTE;
         maddr_ff    <= `TBD_RST_WORD;
         mwdata_ff   <= `TBD_RST_WORD;
         ie_ff       <= `TBD_RST_BIT;
         bip_ff      <= `TBD_RST_BIT;
         ee_ff       <= `TBD_RST_BIT;
         eip_ff      <= `TBD_RST_BIT;
         c_ff        <= `TBD_RST_BIT;
         esr_clr_ff  <= `TBD_RST_BIT;
         rsv_ff      <= `TBD_RST_BIT;
         ld_rsv_ff   <= `TBD_RST_BIT;
         hi_vld_ff   <= `TBD_RST_BIT;
         hi_ff       <= 16'h0000;
         wide_vld_ff <= `TBD_RST_BIT;
         wide_ff     <= 24'h000000;
      end else begin
         state_ff    <= nxt_state;
         ready_ff    <= nxt_ready;
         ill_ff      <= nxt_ill;
         wb_en_ff    <= nxt_wb_en;
         wb_addr_ff  <= nxt_wb_addr;
         wb_data_ff  <= nxt_wb_data;
         br_ff       <= nxt_br;
         br_delay_ff <= nxt_br_delay;
         br_tgt_ff   <= nxt_br_tgt;
         mreq_ff     <= nxt_mreq;
         mwe_ff      <= nxt_mwe;
         msize_ff    <= nxt_msize;
         maddr_ff    <= nxt_maddr;
         mwdata_ff   <= nxt_mwdata;
         ie_ff       <= nxt_ie;
         bip_ff      <= nxt_bip;
         ee_ff       <= nxt_ee;
         eip_ff      <= nxt_eip;
         c_ff        <= nxt_c;
         esr_clr_ff  <= nxt_esr_clr;
         rsv_ff      <= nxt_rsv;
         ld_rsv_ff   <= nxt_ld_rsv;
         hi_vld_ff   <= nxt_hi_vld;
         hi_ff       <= nxt_hi;
         wide_vld_ff <= nxt_wide_vld;
         wide_ff     <= nxt_wide;
      end
   end

   assign ready_o     = ready_ff;
   assign illegal_o   = ill_ff;
   assign wb_en_o     = wb_en_ff;
   assign wb_addr_o   = wb_addr_ff;
   assign wb_data_o   = wb_data_ff;
   assign br_o        = br_ff;
   assign br_delay_o  = br_delay_ff;
   assign br_target_o = br_tgt_ff;
   assign mem_req_o   = mreq_ff;
   assign mem_we_o    = mwe_ff;
   assign mem_size_o  = msize_ff;
   assign mem_addr_o  = maddr_ff;
   assign mem_wdata_o = mwdata_ff;
   assign msr_ie_o    = ie_ff;
   assign msr_bip_o   = bip_ff;
   assign msr_ee_o    = ee_ff;
   assign msr_eip_o   = eip_ff;
   assign msr_c_o     = c_ff;
   assign esr_clear_o = esr_clr_ff;
   assign rsv_o       = rsv_ff;

endmodule // tbd_core

// ---- tbd_core_properties.sv ----
// concurrent checks on the decode stage ports
`timescale 1ns/10ps
module tbd_core_properties (
   input wire        clk_i, rst_n_i, inst_valid_i, mem_ack_i, rsv_clear_i,
   input wire [31:0] instr_i,
   input wire        ready_o, mem_req_o, mem_we_o, wb_en_o, br_o, rsv_o, msr_c_o,
   input wire        msr_ie_o, msr_bip_o, msr_ee_o, msr_eip_o, esr_clear_o,
   input wire [63:0] mem_addr_o
);
   wire       tk   = inst_valid_i && ready_o;
   wire [5:0] op   = instr_i[31:26];
   wire [4:0] dst  = instr_i[25:21];
   wire [4:0] src1 = instr_i[20:16];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_logic_write: assert property (tk && op >= 6'h29 && op <= 6'h2B |=> wb_en_o)
      else $error("logic op gave no write");
   a_intr_return: assert property (tk && op == 6'h2D && dst == 5'h11 |=> br_o && msr_ie_o)
      else $error("interrupt return wrong");
   a_break_return: assert property (tk && op == 6'h2D && dst == 5'h12 |=> br_o && !msr_bip_o)
      else $error("break return wrong");
   a_exc_return: assert property (tk && op == 6'h2D && dst == 5'h14
      |=> esr_clear_o && msr_ee_o && !msr_eip_o)
      else $error("exception return wrong");
   a_barrier_wait: assert property (tk && op == 6'h2E && src1 == 5'h02 |=> !ready_o && !br_o)
      else $error("barrier did not stall");
   a_break_status: assert property (tk && op == 6'h2E && src1 == 5'h0C
      |=> br_o && msr_bip_o && !rsv_o)
      else $error("break literal wrong");
   a_rsv_cause: assert property ($rose(rsv_o) |-> $past(mem_ack_i) && !$past(mem_we_o))
      else $error("reservation set without load");
   a_cond_store_fail: assert property (tk && op == 6'h36 && instr_i[10:0] == 11'h400
      && !rsv_o |=> msr_c_o && !mem_req_o && !rsv_o)
      else $error("failed conditional store wrong");
   a_event_clear: assert property (rsv_clear_i && !mem_ack_i |=> !rsv_o)
      else $error("reservation survived event");
   a_access_hold: assert property (mem_req_o && !mem_ack_i
      |=> mem_req_o && $stable(mem_addr_o) && !ready_o)
      else $error("access dropped before ack");
endmodule // tbd_core_properties

bind tbd_core tbd_core_properties u_tbd_core_properties (.clk_i, .rst_n_i, .inst_valid_i,
   .mem_ack_i, .rsv_clear_i, .instr_i, .ready_o, .mem_req_o, .mem_we_o, .wb_en_o, .br_o, .rsv_o,
   .msr_c_o, .msr_ie_o, .msr_bip_o, .msr_ee_o, .msr_eip_o, .esr_clear_o, .mem_addr_o);

// ---- tbd_mem_model.sv ----
// behavioural memory on the far side of the data port
`timescale 1ns/10ps
module tbd_mem_model (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        req_i,
   input  wire        we_i,
   input  wire        busy_i,
   input  wire [1:0]  lat_i,
   input  wire [63:0] addr_i,
   input  wire [63:0] wdata_i,
   output reg         ack_o,
   output reg  [63:0] rdata_o,
   output reg  [63:0] st_data_o,
   output wire        idle_o
);
   reg [1:0] wait_ff;
   // another master may hold the bus busy
   assign idle_o = !req_i && !busy_i;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o     <= 1'h0;
         wait_ff   <= 2'h0;
         rdata_o   <= 64'h0;
         st_data_o <= 64'h0;
      end else begin
         // read data inverts every cycle outside the ack cycle
         rdata_o <= ~rdata_o;
         ack_o   <= 1'h0;
         if (req_i && !ack_o && wait_ff == lat_i) begin
            ack_o   <= 1'h1;
            wait_ff <= 2'h0;
            rdata_o <= {addr_i[31:0], ~addr_i[31:0]};
            if (we_i)
               st_data_o <= wdata_i;
         end else if (req_i && !ack_o)
            wait_ff <= wait_ff + 2'h1;
      end
   end
endmodule // tbd_mem_model

// ---- tb_top.sv ----
// self-checking bench for the decode stage
`timescale 1ns/10ps
module tb_top;
   logic        clk_i, rst_n_i, mode64_i, inst_valid_i, rsv_clear_i, busy, r;
   logic [31:0] instr_i, seed;
   logic [63:0] pc_i, ra_val_i, rb_val_i, rd_val_i, s_d, s_t, s_a, a, b, d, ea;
   logic [15:0] im;
   logic [10:0] fn;
   logic [5:0]  op;
   logic [4:0]  s_f;
   logic [2:0]  s_z;
   logic [1:0]  lat, sz;
   logic [4:0]  bk [0:10] = '{5'h00, 5'h10, 5'h14, 5'h08, 5'h18, 5'h1C, 5'h0C, 5'h10, 5'h11,
                              5'h12, 5'h14};
   int          i, j, mismatches, n_compared;
   time         t0;
   wire         ready_o, illegal_o, wb_en_o, br_o, br_delay_o, mem_req_o, mem_we_o, msr_ie_o;
   wire         msr_bip_o, msr_ee_o, msr_eip_o, msr_c_o, esr_clear_o, rsv_o, mem_ack_i, mem_idle_i;
   wire [4:0]   wb_addr_o;
   wire [1:0]   mem_size_o;
   wire [63:0]  wb_data_o, br_target_o, mem_addr_o, mem_wdata_o, mem_rdata_i, st_d;

   tbd_core u_tbd_core (.clk_i, .rst_n_i, .mode64_i, .inst_valid_i, .instr_i, .pc_i, .ra_val_i,
      .rb_val_i, .rd_val_i, .rsv_clear_i, .mem_ack_i, .mem_rdata_i, .mem_idle_i, .ready_o,
      .illegal_o, .wb_en_o, .wb_addr_o, .wb_data_o, .br_o, .br_delay_o, .br_target_o, .mem_req_o,
      .mem_we_o, .mem_size_o, .mem_addr_o, .mem_wdata_o, .msr_ie_o, .msr_bip_o, .msr_ee_o,
      .msr_eip_o, .msr_c_o, .esr_clear_o, .rsv_o);
   tbd_mem_model u_tbd_mem_model (.clk_i, .rst_n_i, .req_i(mem_req_o), .we_i(mem_we_o),
      .busy_i(busy), .lat_i(lat), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i),
      .rdata_o(mem_rdata_i), .st_data_o(st_d), .idle_o(mem_idle_i));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // pulses last one cycle, so latch them for the checks
   always @(posedge clk_i) begin
      if (wb_en_o) begin s_f[3] <= 1'b1; s_d <= wb_data_o; end
      if (br_o) begin s_f[2] <= 1'b1; s_f[4] <= br_delay_o; s_t <= br_target_o; end
      if (illegal_o) s_f[1] <= 1'b1;
      if (mem_req_o) begin s_f[0] <= 1'b1; s_a <= mem_addr_o; s_z <= {mem_we_o, mem_size_o}; end
   end

   function [63:0] sx(input [15:0] v);
      sx = {{48{v[15]}}, v};
   endfunction
   function [63:0] msk(input [1:0] s);
      msk = s == 2'h3 ? '1 : (64'h1 << (8 << s)) - 64'h1;
   endfunction
   function bit hit(input int c, input [63:0] v);
      case (c)
         0: hit = v == 0;
         1: hit = v != 0;
         2: hit = $signed(v) < 0;
         3: hit = $signed(v) <= 0;
         4: hit = $signed(v) > 0;
         default: hit = $signed(v) >= 0;
      endcase
   endfunction

   task chk(input string nm, input [63:0] e, g);
      n_compared++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask
   task final_report;
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // offer one instruction, then wait until the stage is free again
   task run(input [31:0] w, input [63:0] x, y, z);
      int k;
      s_f = 5'h0; s_d = 'x; s_t = 'x; s_a = 'x; s_z = 'x;
      pc_i = {$random(seed), $random(seed)};
      instr_i = w; ra_val_i = x; rb_val_i = y; rd_val_i = z; inst_valid_i = 1'b1;
      @(posedge clk_i);
      #1 inst_valid_i = 1'b0;
      for (k = 0; k < 40 && ready_o !== 1'b1; k++) begin
         @(posedge clk_i);
         #1;
      end
      @(posedge clk_i);
      #1;
      if (k == 40) begin
         mismatches++;
         final_report;
      end
   endtask

   initial begin
      seed = 32'hF3D8; mismatches = 0; n_compared = 0; rst_n_i = 1'b0; mode64_i = 1'b1;
      inst_valid_i = 1'b0; rsv_clear_i = 1'b0; busy = 1'b0; lat = 2'h0; instr_i = 32'h0;
      pc_i = 64'h0; ra_val_i = 64'h0; rb_val_i = 64'h0; rd_val_i = 64'h0;
      repeat (4) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      for (i = 0; i < 12; i++) begin
         im = i ? $random(seed) : 16'h8000;
         a = {$random(seed), $random(seed)};
         run({6'(6'h29 + i % 3), 10'h0A6, im}, a, 0, 0);
         chk("logic", i % 3 == 0 ? a & sx(im) : i % 3 == 1 ? a ^ sx(im) : a & ~sx(im), s_d);
         chk("dest", 5, wb_addr_o);
      end
      run({6'h2C, 10'h0, 16'h9234}, 0, 0, 0);
      run({6'h29, 10'h0A6, 16'h8001}, a, 0, 0);
      chk("upper_lit", a & 64'hFFFFFFFF92348001, s_d);
      run({6'h2C, 2'h2, 24'h800001}, 0, 0, 0);
      run({6'h2A, 10'h0A6, 16'h0002}, a, 0, 0);
      chk("wide_lit", a ^ 64'hFFFFFF8000010002, s_d);
      run({6'h2A, 10'h0A6, 16'h0005}, a, 0, 0);
      chk("plain_lit", a ^ 64'h5, s_d);
      for (i = 0; i < 11; i++) begin
         im = $random(seed);
         a = {$random(seed), $random(seed)};
         run(i < 7 ? {6'h2E, 5'h7, bk[i], im} : {6'h2D, bk[i], 5'h3, im}, a, 0, 0);
         chk("target", i > 6 ? a + sx(im) : bk[i][3] ? sx(im) : pc_i + sx(im), s_t);
         if (i < 7) chk("delay", bk[i][4], s_f[4]);
         if (i < 7 && bk[i][2]) chk("link", pc_i, s_d);
         if (i == 6) chk("break_bit", 1, msr_bip_o);
      end
      chk("status", 4'hA, {msr_ie_o, msr_bip_o, msr_ee_o, msr_eip_o});
      for (i = 0; i < 36; i++) begin
         im = $random(seed);
         a = (i / 6) % 3 == 0 ? 64'h0 : {$random(seed), $random(seed)};
         run({6'h2F, i >= 18, 1'b0, 3'(i % 6), 5'h3, im}, a, 0, 0);
         chk("cond", {hit(i % 6, a), hit(i % 6, a) && i >= 18}, {s_f[2], s_f[4]});
         if (hit(i % 6, a)) chk("cond_target", pc_i + sx(im), s_t);
      end
      for (j = 0; j < 2; j++)
         for (i = 0; i < 9; i++) begin
            im = $random(seed); lat = $random(seed);
            a = {32'h0, $random(seed)}; b = {32'h0, $random(seed)}; d = {$random(seed), $random(seed)};
            r = i < 3 || i > 6;
            op = 6'((i < 3 ? 6'h30 + i : i < 7 ? 6'h35 + i : 6'h32) + 4 * j);
            fn = i == 7 ? 11'h080 : i == 8 ? 11'h100 : 11'h000;
            ea = i == 7 ? {a[31:0], b[31:0]} : r ? a + b : a + sx(im);
            sz = 2'(i < 3 ? i : i < 7 ? i - 3 : i == 8 ? 3 : 2);
            run(r ? {op, 15'h14C7, fn} : {op, 10'h0A6, im}, a, b, d);
            chk("addr", ea, s_a);
            chk("kind", {j[0], sz}, s_z);
            if (j) chk("st_data", d & msk(sz), st_d);
            else chk("ld_data", {ea[31:0], ~ea[31:0]} & msk(sz), s_d);
         end
      run({6'h32, 15'h14C7, 11'h400}, a, b, 0);
      chk("rsv_set", 1, rsv_o);
      d = {$random(seed), $random(seed)};
      run({6'h36, 15'h14C7, 11'h400}, a, b, d);
      chk("swap_ok", {2'h0, d[31:0]}, {rsv_o, msr_c_o, st_d[31:0]});
      run({6'h36, 15'h14C7, 11'h400}, a, b, ~d);
      chk("swap_fail", {3'h2, d[31:0]}, {rsv_o, msr_c_o, s_f[0], st_d[31:0]});
      run({6'h32, 15'h14C7, 11'h400}, a, b, 0);
      rsv_clear_i = 1'b1;
      @(posedge clk_i);
      #1 rsv_clear_i = 1'b0;
      chk("rsv_drop", 0, rsv_o);
      busy = 1'b1;
      t0 = $time;
      fork
         begin
            repeat (5) @(posedge clk_i);
            #1 busy = 1'b0;
         end
      join_none
      run({6'h2E, 5'h9, 5'h02, 16'h0}, 0, 0, 0);
      chk("barrier", pc_i + 64'h4, s_t);
      chk("barrier_wait", 1, $time - t0 > 120);
      mode64_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      for (i = 0; i < 3; i++) begin
         run(i == 0 ? {6'h3B, 10'h0A6, 16'h8} : i == 1 ? {6'h3F, 10'h0A6, 16'h8}
            : {6'h2C, 2'h2, 24'h1}, a, b, d);
         chk("illegal", 2'h2, s_f[1:0]);
      end
      final_report;
   end
endmodule // tb_top
